// ==== logic/lfw_pkg.sv ====
// Function
// - Manchester mode passes only data bytes after ID
// - Mode field 1:0 selects Manchester data
// - Mode field 0:0 selects direct mode
// - Mode field 01 selects carrier detect
// - Manchester on-time fixed at two slow ticks
// - Rate field sets period, 0100 is 16 ms
// - Rate code 0101 gives 32 ms period
// - Interrupt enable wakes CPU per data byte
// - Coding error status while resting between samples
// - Off-time bit rests one or two periods
// - Receiver samples only while enable bit set
// - Code-length bit picks 8 or 16 bits
// - Gain select bit picks data or AGC readout
// - Data-available flag marks waiting byte
// - Match flags for wake-up codes B and A
// - Detect status 0 valid, 1 data ended
// - Ignore bit holds detector input low, except the raw detector status bit in direct mode
// - Direct mode exposes raw detector status bit
// - Direct mode uses only the sensitivity setting
// - Re-enable runs a 32 us auto-zero
// - Direct mode ignores wake-up code registers
package lfw_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CS0 = 8'h04;
    localparam logic [7:0] OFS_CS1 = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0c;
    localparam logic [7:0] OFS_CODE_A = 8'h10;
    localparam logic [7:0] OFS_CODE_B = 8'h14;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CS0_RST = 8'h00;
    localparam logic [7:0] CS0_RW_MASK = 8'h5f;
    localparam logic [15:0] CODE_RST = 16'h0000;

    localparam int CS0_RAW = 7;
    localparam int CS0_IE = 6;
    localparam int CS0_ERR_REST = 5;
    localparam int CS0_OFF_SEL = 4;
    localparam int CS0_EN = 3;
    localparam int CS0_LEN16 = 2;
    localparam int CS0_SENS = 1;
    localparam int CS0_AGC = 0;
    localparam int CS1_DF = 7;
    localparam int CS1_DACK = 6;
    localparam int CS1_CF = 5;
    localparam int CS1_CACK = 4;
    localparam int CS1_BF = 3;
    localparam int CS1_AF = 2;
    localparam int CS1_MDD = 1;
    localparam int CS1_IG = 0;

    localparam int CLK_PERIOD_NS = 20;
    localparam int SLOW_PERIOD_NS = 1000000;
    localparam int SLOW_TICK_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;
    localparam int AUTOZERO_NS = 32000;
    localparam int AZ_CYC = (AUTOZERO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MANCH_ON_TICKS = 2;
    localparam int CARR_ON_SHORT_TICKS = 1;
    localparam int CARR_ON_LONG_TICKS = 3;

    typedef enum logic [1:0] {
        LFW_MODE_DIRECT = 2'b00,
        LFW_MODE_CARRIER = 2'b01,
        LFW_MODE_MANCH = 2'b10,
        LFW_MODE_RSVD = 2'b11
    } lfw_mode_t;

    typedef struct packed {
        lfw_mode_t mode;
        logic char_len;
        logic on_sel;
        logic [3:0] rate;
    } lfw_ctrl_t;

    typedef struct packed {
        logic valid;
        logic bit_val;
        logic err;
    } lfw_sym_t;
endpackage : lfw_pkg

// ==== logic/lfw_tick.sv ====
`timescale 1ns/1ps
module lfw_tick #(
    parameter int DIV = lfw_pkg::SLOW_TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic tick_o
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt_reg;

    // Period restarts at enable so the first tick comes a full tick period after enable
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !run_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_reg == LAST);
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule : lfw_tick

// ==== logic/lfw_frame.sv ====
`timescale 1ns/1ps
module lfw_frame (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic active_i,
    input wire logic sync_i,
    input wire lfw_pkg::lfw_sym_t sym_i,
    input wire logic len16_i,
    input wire logic [15:0] code_a_i,
    input wire logic [15:0] code_b_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic match_a_o,
    output logic match_b_o,
    output logic err_o,
    output logic in_frame_o
);
    typedef enum logic [1:0] {
        FRM_HUNT = 2'b00,
        FRM_CODE = 2'b01,
        FRM_DATA = 2'b10
    } lfw_frm_t;

    lfw_frm_t state_reg;
    logic [15:0] shift_reg;
    logic [15:0] shift_next;
    logic [3:0] cnt_reg;
    logic [3:0] code_last;
    logic hit_a;
    logic hit_b;

    assign shift_next = {shift_reg[14:0], sym_i.bit_val};
    assign code_last = len16_i ? 4'hf : 4'h7;
    assign hit_a = len16_i ? (shift_next == code_a_i) : (shift_next[7:0] == code_a_i[7:0]);
    assign hit_b = len16_i ? (shift_next == code_b_i) : (shift_next[7:0] == code_b_i[7:0]);
    assign in_frame_o = (state_reg != FRM_HUNT);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !active_i) begin
            state_reg <= FRM_HUNT;
            shift_reg <= '0;
            cnt_reg <= '0;
            byte_valid_o <= 1'b0;
            byte_o <= '0;
            match_a_o <= 1'b0;
            match_b_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            byte_valid_o <= 1'b0;
            match_a_o <= 1'b0;
            match_b_o <= 1'b0;
            err_o <= 1'b0;
            unique case (state_reg)
                FRM_HUNT: begin
                    cnt_reg <= '0;
                    if (sync_i) begin
                        state_reg <= FRM_CODE;
                    end
                end
                FRM_CODE: begin
                    if (sym_i.valid && sym_i.err) begin
                        state_reg <= FRM_HUNT;
                    end else if (sym_i.valid) begin
                        shift_reg <= shift_next;
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg == code_last) begin
                            // Message ID is consumed here and never reaches the data register
                            cnt_reg <= '0;
                            match_a_o <= hit_a;
                            match_b_o <= hit_b;
                            state_reg <= (hit_a || hit_b) ? FRM_DATA : FRM_HUNT;
                        end
                    end
                end
                FRM_DATA: begin
                    if (sym_i.valid && sym_i.err) begin
                        err_o <= 1'b1;
                        state_reg <= FRM_HUNT;
                    end else if (sym_i.valid) begin
                        shift_reg <= shift_next;
                        cnt_reg <= {1'b0, cnt_reg[2:0] + 3'h1};
                        if (cnt_reg[2:0] == 3'h7) begin
                            byte_o <= shift_next[7:0];
                            byte_valid_o <= 1'b1;
                        end
                    end
                end
                default: state_reg <= FRM_HUNT;
            endcase
        end
    end
endmodule : lfw_frame

// ==== logic/lfw_receiver.sv ====
`timescale 1ns/1ps
module lfw_receiver #(
    parameter int SLOW_TICK_CYC = lfw_pkg::SLOW_TICK_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic det_i,
    input wire logic sync_i,
    input wire lfw_pkg::lfw_sym_t sym_i,
    input wire logic carrier_i,
    input wire logic [7:0] agc_level_i,
    output logic irq_o,
    output logic rx_on_o,
    output logic autozero_o,
    output logic low_sens_o
);
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_AZERO = 2'b01,
        SEQ_ON = 2'b10,
        SEQ_OFF = 2'b11
    } lfw_seq_t;

    localparam logic [16:0] AZ_LAST = 17'(lfw_pkg::AZ_CYC - 1);
    localparam logic [16:0] MANCH_LAST = 17'(lfw_pkg::MANCH_ON_TICKS - 1);
    localparam logic [16:0] CARR_SHORT_LAST = 17'(lfw_pkg::CARR_ON_SHORT_TICKS - 1);
    localparam logic [16:0] CARR_LONG_LAST = 17'(lfw_pkg::CARR_ON_LONG_TICKS - 1);

    lfw_pkg::lfw_ctrl_t ctrl_reg;
    logic [7:0] cs0_reg;
    logic ignore_reg;
    logic [15:0] code_a_reg;
    logic [15:0] code_b_reg;
    logic [7:0] data_reg;
    logic data_flag_reg;
    logic carrier_flag_reg;
    logic flag_a_reg;
    logic flag_b_reg;
    logic mdd_reg;
    logic err_rest_reg;
    logic raw_det_reg;
    lfw_seq_t seq_state_reg;
    logic [16:0] seq_cnt_reg;

    logic en;
    logic is_manch;
    logic is_direct;
    logic slow_tick;
    logic [16:0] on_last;
    logic [16:0] off_last;
    logic [16:0] off_ticks;
    logic setup;
    logic wr_en;
    logic mapped;
    logic [7:0] rd_mux;
    logic data_ack;
    logic carrier_ack;
    logic sampling;
    lfw_pkg::lfw_sym_t sym_gated;
    logic frm_byte_valid;
    logic [7:0] frm_byte;
    logic frm_match_a;
    logic frm_match_b;
    logic frm_err;
    logic frm_in_frame;
    logic carrier_set;

    ////////////////////////////////////////////////////////////////////////
    // Decode of configuration

    assign en = cs0_reg[lfw_pkg::CS0_EN];
    assign is_manch = (ctrl_reg.mode == lfw_pkg::LFW_MODE_MANCH);
    assign is_direct = (ctrl_reg.mode == lfw_pkg::LFW_MODE_DIRECT);
    assign sampling = (seq_state_reg == SEQ_ON);
    // Manchester ignores the on-time select bit
    assign on_last = is_manch ? MANCH_LAST : (ctrl_reg.on_sel ? CARR_LONG_LAST : CARR_SHORT_LAST);
    // One slow tick is one ms, so the period is two to the rate code in ms
    assign off_ticks = (17'h00001 << ctrl_reg.rate) << cs0_reg[lfw_pkg::CS0_OFF_SEL];
    assign off_last = off_ticks - 17'h00001;
    // Ignored detector reads as a constant low line to the decoder
    assign sym_gated = ignore_reg ? '0 : sym_i;
    assign carrier_set = sampling && (ctrl_reg.mode == lfw_pkg::LFW_MODE_CARRIER) && carrier_i && !ignore_reg;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states, answer registered in the setup cycle

    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    assign data_ack = wr_en && (paddr_i == lfw_pkg::OFS_CS1) && pwdata_i[lfw_pkg::CS1_DACK];
    assign carrier_ack = wr_en && (paddr_i == lfw_pkg::OFS_CS1) && pwdata_i[lfw_pkg::CS1_CACK];

    always_comb begin
        mapped = 1'b1;
        rd_mux = 8'h00;
        unique case (paddr_i)
            lfw_pkg::OFS_CTRL: rd_mux = ctrl_reg;
            lfw_pkg::OFS_CS0: begin
                rd_mux = cs0_reg & lfw_pkg::CS0_RW_MASK;
                rd_mux[lfw_pkg::CS0_RAW] = raw_det_reg;
                rd_mux[lfw_pkg::CS0_ERR_REST] = err_rest_reg;
            end
            lfw_pkg::OFS_CS1: begin
                // Acknowledge bits read as zero
                rd_mux = {data_flag_reg, 1'b0, carrier_flag_reg, 1'b0,
                          flag_b_reg, flag_a_reg, mdd_reg, ignore_reg};
            end
            lfw_pkg::OFS_DATA: rd_mux = cs0_reg[lfw_pkg::CS0_AGC] ? agc_level_i : data_reg;
            lfw_pkg::OFS_CODE_A: rd_mux = code_a_reg[7:0];
            lfw_pkg::OFS_CODE_B: rd_mux = code_b_reg[7:0];
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup && !mapped;
            if (setup && !pwrite_i) begin
                // Wake-up codes are 16 bits wide and read back in full
                if (paddr_i == lfw_pkg::OFS_CODE_A) begin
                    prdata_o <= {16'h0000, code_a_reg};
                end else if (paddr_i == lfw_pkg::OFS_CODE_B) begin
                    prdata_o <= {16'h0000, code_b_reg};
                end else begin
                    prdata_o <= {24'h000000, rd_mux};
                end
            end else begin
                prdata_o <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= lfw_pkg::CTRL_RST;
            cs0_reg <= lfw_pkg::CS0_RST;
            ignore_reg <= 1'b0;
            code_a_reg <= lfw_pkg::CODE_RST;
            code_b_reg <= lfw_pkg::CODE_RST;
        end else if (wr_en) begin
            unique case (paddr_i)
                lfw_pkg::OFS_CTRL: ctrl_reg <= pwdata_i[7:0];
                lfw_pkg::OFS_CS0: cs0_reg <= pwdata_i[7:0] & lfw_pkg::CS0_RW_MASK;
                lfw_pkg::OFS_CS1: ignore_reg <= pwdata_i[lfw_pkg::CS1_IG];
                lfw_pkg::OFS_CODE_A: code_a_reg <= pwdata_i[15:0];
                lfw_pkg::OFS_CODE_B: code_b_reg <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampling sequencer: auto-zero, on window, rest

    lfw_tick #(
        .DIV(SLOW_TICK_CYC)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .run_i(en),
        .tick_o(slow_tick)
    );

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !en) begin
            seq_state_reg <= SEQ_IDLE;
            seq_cnt_reg <= '0;
        end else begin
            unique case (seq_state_reg)
                SEQ_IDLE: begin
                    seq_state_reg <= SEQ_AZERO;
                    seq_cnt_reg <= '0;
                end
                SEQ_AZERO: begin
                    if (seq_cnt_reg == AZ_LAST) begin
                        seq_state_reg <= SEQ_ON;
                        seq_cnt_reg <= '0;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 17'h00001;
                    end
                end
                SEQ_ON: begin
                    // Direct mode keeps the detector on until software cycles the enable
                    if (!is_direct && slow_tick) begin
                        if (seq_cnt_reg >= on_last) begin
                            // A frame in progress holds the receiver on to its end
                            if (!(is_manch && frm_in_frame)) begin
                                seq_state_reg <= SEQ_OFF;
                                seq_cnt_reg <= '0;
                            end
                        end else begin
                            seq_cnt_reg <= seq_cnt_reg + 17'h00001;
                        end
                    end
                end
                SEQ_OFF: begin
                    if (slow_tick) begin
                        if (seq_cnt_reg >= off_last) begin
                            seq_state_reg <= SEQ_AZERO;
                            seq_cnt_reg <= '0;
                        end else begin
                            seq_cnt_reg <= seq_cnt_reg + 17'h00001;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_on_o <= 1'b0;
            autozero_o <= 1'b0;
            low_sens_o <= 1'b0;
        end else begin
            rx_on_o <= en && (seq_state_reg == SEQ_AZERO || seq_state_reg == SEQ_ON);
            autozero_o <= en && (seq_state_reg == SEQ_AZERO);
            low_sens_o <= cs0_reg[lfw_pkg::CS0_SENS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Manchester frame decoder, idle outside Manchester mode

    lfw_frame u_frame (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .active_i(sampling && is_manch),
        .sync_i(sync_i && !ignore_reg),
        .sym_i(sym_gated),
        .len16_i(cs0_reg[lfw_pkg::CS0_LEN16]),
        .code_a_i(code_a_reg),
        .code_b_i(code_b_reg),
        .byte_valid_o(frm_byte_valid),
        .byte_o(frm_byte),
        .match_a_o(frm_match_a),
        .match_b_o(frm_match_b),
        .err_o(frm_err),
        .in_frame_o(frm_in_frame)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status flags; a set in the same cycle as an acknowledge wins

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_reg <= 8'h00;
        end else if (frm_byte_valid) begin
            data_reg <= frm_byte;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_flag_reg <= 1'b0;
            flag_a_reg <= 1'b0;
            flag_b_reg <= 1'b0;
        end else begin
            data_flag_reg <= frm_byte_valid || (data_flag_reg && !data_ack);
            flag_a_reg <= frm_match_a || (flag_a_reg && !data_ack);
            flag_b_reg <= frm_match_b || (flag_b_reg && !data_ack);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            carrier_flag_reg <= 1'b0;
        end else begin
            carrier_flag_reg <= carrier_set || (carrier_flag_reg && !carrier_ack);
        end
    end

    // Detect status clears when the enable drops or a new code matches
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !en) begin
            mdd_reg <= 1'b0;
        end else if (frm_err) begin
            mdd_reg <= 1'b1;
        end else if (frm_match_a || frm_match_b) begin
            mdd_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            err_rest_reg <= 1'b0;
            raw_det_reg <= 1'b0;
        end else begin
            err_rest_reg <= (seq_state_reg == SEQ_OFF) && mdd_reg;
            // Direct mode is not masked by the ignore bit, only by power state
            raw_det_reg <= sampling && det_i && (is_direct || !ignore_reg);
        end
    end

    // Level interrupt held until the flag is acknowledged
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= cs0_reg[lfw_pkg::CS0_IE] && (data_flag_reg || carrier_flag_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [16:0] off_seen_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || seq_state_reg != SEQ_OFF) begin
            off_seen_reg <= '0;
        end else if (slow_tick) begin
            off_seen_reg <= off_seen_reg + 17'h00001;
        end
    end

    // Independent count of auto-zero cycles, checked when the on window opens
    logic [16:0] az_seen_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || seq_state_reg != SEQ_AZERO) begin
            az_seen_reg <= '0;
        end else begin
            az_seen_reg <= az_seen_reg + 17'h00001;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_byte_in;
        frm_byte_valid && cs0_reg[lfw_pkg::CS0_IE];
    endsequence

    sequence s_irq_up;
        ##[1:2] irq_o;
    endsequence

    frame_mode_a: assert property (frm_in_frame |-> $past(is_manch))
        else $error("frame decoder active outside Manchester mode");
    direct_raw_a: assert property ((sampling && is_direct) |=> raw_det_reg == $past(det_i))
        else $error("raw detector bit does not follow detector in direct mode");
    manch_on_a: assert property ((sampling && is_manch && slow_tick && seq_cnt_reg == 17'h00001 && !frm_in_frame)
        |=> seq_state_reg == SEQ_OFF)
        else $error("Manchester on window not two slow ticks");
    rest_len_a: assert property (($past(seq_state_reg) == SEQ_OFF && seq_state_reg == SEQ_AZERO)
        |-> off_seen_reg == off_ticks)
        else $error("rest length differs from selected sample periods");
    byte_irq_a: assert property (s_byte_in |-> s_irq_up)
        else $error("no interrupt after data byte");
    data_flag_a: assert property (frm_byte_valid |=> data_flag_reg && data_reg == $past(frm_byte))
        else $error("data byte not flagged");
    ack_clear_a: assert property ((data_ack && !frm_byte_valid && !frm_match_a && !frm_match_b)
        |=> !data_flag_reg && !flag_a_reg && !flag_b_reg)
        else $error("acknowledge did not clear flags");
    match_b_a: assert property (frm_match_b |=> flag_b_reg)
        else $error("code B match not flagged");
    enable_off_a: assert property ((!en ##1 !en) |=> !rx_on_o && !autozero_o)
        else $error("receiver on while disabled");
    agc_read_a: assert property ((setup && !pwrite_i && paddr_i == lfw_pkg::OFS_DATA)
        |=> prdata_o[7:0] == ($past(cs0_reg[lfw_pkg::CS0_AGC]) ? $past(agc_level_i) : $past(data_reg)))
        else $error("data register readout select wrong");
    mdd_end_a: assert property (frm_err |=> mdd_reg)
        else $error("detect status not set on coding violation");
    err_rest_a: assert property ((seq_state_reg == SEQ_OFF && mdd_reg) |=> err_rest_reg)
        else $error("coding error rest status missing");
    autozero_len_a: assert property (($past(seq_state_reg) == SEQ_AZERO && seq_state_reg == SEQ_ON)
        |-> $past(az_seen_reg) == AZ_LAST)
        else $error("auto-zero length differs from required");
endmodule : lfw_receiver

// ==== testbench/lfw_tx_model.sv ====
`timescale 1ns/1ps
module lfw_tx_model (
    input wire logic ref_clk_i,
    output logic sync_o,
    output lfw_pkg::lfw_sym_t sym_o
);
    initial begin
        sync_o = 1'b0;
        sym_o = '0;
    end
    // Sync mark, then code and data bits MSB first, one per clock
    task automatic send_frame(input logic [7:0] code, input logic [7:0] data);
        logic [15:0] bits;
        bits = {code, data};
        @(posedge ref_clk_i) sync_o <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge ref_clk_i);
            sync_o <= 1'b0;
            sym_o <= '{1'b1, bits[i], 1'b0};
        end
        // A coding violation closes the frame, as a real datagram ends
        @(posedge ref_clk_i) sym_o <= '{1'b1, bits[0], 1'b1};
        // Idle bit line flips so a stale level is never mistaken for data
        @(posedge ref_clk_i) sym_o <= '{1'b0, ~bits[0], 1'b0};
    endtask : send_frame
endmodule : lfw_tx_model

// ==== testbench/tb_lfw_receiver.sv ====
`timescale 1ns/1ps
module tb_lfw_receiver;
    logic ref_clk_i, rst_i, psel, penable, pwrite, det, pready, pslverr, irq, rx_on, low_sens, sync, az, carr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic e;
    lfw_pkg::lfw_sym_t sym;
    int n_mismatch = 0;
    int tests_run = 0;
    lfw_receiver #(.SLOW_TICK_CYC(20)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .det_i(det), .sync_i(sync), .sym_i(sym), .carrier_i(carr),
        .agc_level_i(8'h3c), .irq_o(irq), .rx_on_o(rx_on), .autozero_o(az), .low_sens_o(low_sens));
    lfw_tx_model i_tx (.ref_clk_i(ref_clk_i), .sync_o(sync), .sym_o(sym));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait for a slave that never answers
        @(posedge ref_clk_i);
        while (pready !== 1'b1) @(posedge ref_clk_i);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_on();
        int n;
        n = 0;
        while (az !== 1'b1) @(posedge ref_clk_i);
        while (az === 1'b1) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(n, lfw_pkg::AZ_CYC, "auto-zero length");
        chk({31'h0, rx_on}, 32'h1, "receiver on");
    endtask : wait_on
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'b0, lfw_pkg::OFS_CS0, 32'h0);
        chk(r, 32'h0, "cs0 reset");
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        $display("reset test done");
    endtask : t_reset
    task automatic t_manch();
        apb(1'b1, lfw_pkg::OFS_CODE_A, 32'h5a);
        apb(1'b1, lfw_pkg::OFS_CTRL, 32'h84);
        apb(1'b1, lfw_pkg::OFS_CS1, 32'h40);
        apb(1'b1, lfw_pkg::OFS_CS0, 32'h48);
        wait_on();
        i_tx.send_frame(8'h5a, 8'hc3);
        repeat (4) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h1, "irq");
        apb(1'b0, lfw_pkg::OFS_CS1, 32'h0);
        chk(r, 32'h86, "flags");
        apb(1'b0, lfw_pkg::OFS_DATA, 32'h0);
        chk(r, 32'hc3, "data");
        apb(1'b1, lfw_pkg::OFS_CS0, 32'h49);
        apb(1'b0, lfw_pkg::OFS_DATA, 32'h0);
        chk(r, 32'h3c, "agc");
        apb(1'b1, lfw_pkg::OFS_CS1, 32'h40);
        apb(1'b0, lfw_pkg::OFS_CS1, 32'h0);
        chk(r, 32'h2, "ack");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // Frame ended in a violation and the receiver now rests
        repeat (20) @(posedge ref_clk_i);
        apb(1'b0, lfw_pkg::OFS_CS0, 32'h0);
        chk(r, 32'h69, "error rest status");
        $display("manchester test done");
    endtask : t_manch
    task automatic t_direct();
        apb(1'b1, lfw_pkg::OFS_CS0, 32'h0);
        apb(1'b1, lfw_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, lfw_pkg::OFS_CS0, 32'h0a);
        wait_on();
        det <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        apb(1'b0, lfw_pkg::OFS_CS0, 32'h0);
        chk(r, 32'h8a, "raw detector");
        chk({31'h0, low_sens}, 32'h1, "sensitivity");
        det <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        apb(1'b0, lfw_pkg::OFS_CS0, 32'h0);
        chk(r, 32'h0a, "raw detector low");
        $display("direct test done");
    endtask : t_direct
    task automatic t_carrier();
        apb(1'b1, lfw_pkg::OFS_CS0, 32'h0);
        apb(1'b1, lfw_pkg::OFS_CTRL, 32'h40);
        apb(1'b1, lfw_pkg::OFS_CS1, 32'h10);
        apb(1'b1, lfw_pkg::OFS_CS0, 32'h4a);
        wait_on();
        carr <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h1, "carrier irq");
        carr <= 1'b0;
        apb(1'b0, lfw_pkg::OFS_CS1, 32'h0);
        chk(r, 32'h20, "carrier flag");
        apb(1'b1, lfw_pkg::OFS_CS1, 32'h10);
        apb(1'b0, lfw_pkg::OFS_CS1, 32'h0);
        chk(r, 32'h0, "carrier ack");
        $display("carrier test done");
    endtask : t_carrier
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        close_out();
    end
    initial begin
        rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0; det = 1'b0;
        carr = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_manch();
        t_direct();
        t_carrier();
        close_out();
    end
endmodule : tb_lfw_receiver
